// *** hdl/nsc_pkg.sv ***
/*
 * Package of the node switch configuration bank: register numbers, field
 * positions, reset values and the request/answer carriers.
 * Assumes a single 200 MHz switch clock domain.
 */
`default_nettype none
package nsc_pkg;

    // =========================================================
    // Register numbers
    localparam logic [7:0] NSC_REG_IDENT    = 8'h00;
    localparam logic [7:0] NSC_REG_TOPO     = 8'h01;
    localparam logic [7:0] NSC_REG_PROT     = 8'h04;
    localparam logic [7:0] NSC_REG_NODEID   = 8'h05;
    localparam logic [7:0] NSC_REG_PLL      = 8'h06;
    localparam logic [7:0] NSC_REG_SWDIV    = 8'h07;
    localparam logic [7:0] NSC_REG_REFDIV   = 8'h08;
    localparam logic [7:0] NSC_REG_SCANID   = 8'h09;
    localparam logic [7:0] NSC_REG_USER     = 8'h0A;
    localparam logic [7:0] NSC_REG_DIRLO    = 8'h0C;
    localparam logic [7:0] NSC_REG_DIRHI    = 8'h0D;
    localparam logic [7:0] NSC_REG_RSVA     = 8'h10;
    localparam logic [7:0] NSC_REG_RSVB     = 8'h11;

    // =========================================================
    // Field positions
    localparam int NSC_PROT_CTL_BIT   = 31;
    localparam int NSC_PROT_PLL_BIT   = 8;
    localparam int NSC_PROT_HDR_BIT   = 0;
    localparam int NSC_PLL_NORST_BIT  = 31;
    localparam int NSC_PLL_NOWAIT_BIT = 30;
    localparam int NSC_PLL_BYP_BIT    = 29;
    localparam int NSC_PLL_JTAG_BIT   = 28;
    localparam int NSC_PLL_OD_MSB     = 25;
    localparam int NSC_PLL_OD_LSB     = 23;
    localparam int NSC_PLL_F_MSB      = 20;
    localparam int NSC_PLL_F_LSB      = 8;
    localparam int NSC_PLL_R_MSB      = 6;
    localparam int NSC_PLL_R_LSB      = 0;
    localparam int NSC_USER_SPLIT     = 18;

    // Writable bits of each register
    localparam logic [31:0] NSC_PROT_MASK = 32'h8000_0101;
    localparam logic [31:0] NSC_PLL_MASK  = 32'hF39F_FF7F;
    localparam logic [31:0] NSC_HALF_MASK = 32'h0000_FFFF;
    localparam logic [31:0] NSC_RSV_MASK  = 32'h0000_0003;

    // =========================================================
    // Reset values
    localparam logic [31:0] NSC_PROT_RST   = 32'h0000_0000;
    localparam logic [15:0] NSC_NODEID_RST = 16'h0000;
    localparam logic [31:0] NSC_PLL_RST    = 32'h0000_0000;
    localparam logic [15:0] NSC_SWDIV_RST  = 16'h0000;
    localparam logic [15:0] NSC_REFDIV_RST = 16'h0003;
    localparam logic [31:0] NSC_DIR_RST    = 32'h0000_0000;
    localparam logic [1:0]  NSC_RSV_RST    = 2'h0;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  regnum;
        logic [31:0] wdata;
    } nsc_req_s;

    typedef struct packed {
        logic        valid;
        logic        ack;
        logic [31:0] rdata;
    } nsc_rsp_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] dest;
    } nsc_route_req_s;

    typedef struct packed {
        logic        valid;
        logic        local_hit;
        logic [3:0]  direction;
    } nsc_route_rsp_s;

endpackage : nsc_pkg

`default_nettype wire

// *** hdl/nsc_config_bank.sv ***
/*
 * Node switch configuration bank: the register file reached by node
 * configuration reads and writes, plus the dimension-order route lookup.
 * Assumes requests arrive synchronous to i_mclk, one per cycle at most,
 * and that identity and topology values are static inputs.
 */
// Overview of operation
// R1: Registers reachable only via configuration read/write requests carrying a register number.
// R2: Identification shows boot pins captured at reset, revision and version.
// R3: Topology register reports link count, switch processors, device processors.
// R4: Protection bit 31 set blocks writes to switch control registers.
// R5: Protection bit 8 set blocks writes to the PLL register.
// R6: Protection bit 0 picks header length: zero two bytes, one single byte.
// R7: Node identity is sixteen writable bits resetting zero; upper half reserved.
// R8: Any accepted PLL register write pulses the tile reset.
// R9: PLL write with bit 31 set suppresses the chip reset.
// R10: PLL bit 30 set skips waiting for PLL relock.
// R11: PLL bit 29 places the PLL in bypass.
// R12: PLL bit 28 switches boot mode to the scan port.
// R13: PLL holds output divider, feedback multiplier and input divider fields.
// R14: Switch clock divider is sixteen writable bits resetting zero.
// R15: Reference clock divider is sixteen writable bits resetting three.
// R16: Scan identification register is read-only, full 32-bit code.
// R17: User code register returns programmed code high and metal code low.
// R18: Low directions hold eight nibbles for identity bits 7..0.
// R19: High directions hold eight nibbles for identity bits 15..8.
// R20: Route by direction of most significant differing identity bit.
// R21: Blocked writes change nothing and still complete normally.
`timescale 1ns/1ps
`default_nettype none

module nsc_config_bank
    import nsc_pkg::*;
#(
    parameter logic [7:0]  SWITCH_REVISION = 8'h01,
    parameter logic [7:0]  SWITCH_VERSION  = 8'h01,
    parameter logic [7:0]  LINK_COUNT      = 8'h08,
    parameter logic [7:0]  SWITCH_PROCS    = 8'h02,
    parameter logic [7:0]  DEVICE_PROCS    = 8'h04,
    // Arbitrary identification values, not those of any part
    parameter logic [31:0] SCAN_ID_CODE    = 32'h0000_0001,
    parameter logic [17:0] METAL_ID_CODE   = 18'h0_0000
)(
    // Clock and reset
    input  wire logic            i_mclk,
    input  wire logic            i_reset_n,
    // Strap and fuse inputs
    input  wire logic [7:0]      i_boot_control_pins,
    input  wire logic [13:0]     i_otp_user_code,
    // Configuration requests
    input  wire nsc_pkg::nsc_req_s       i_req,
    output var   nsc_pkg::nsc_rsp_s      o_rsp,
    // Route lookup
    input  wire nsc_pkg::nsc_route_req_s i_route,
    output var   nsc_pkg::nsc_route_rsp_s o_route,
    // Controls to the rest of the node
    output logic                 o_one_byte_header,
    output logic [15:0]          o_node_id,
    output logic                 o_tile_reset,
    output logic                 o_chip_reset,
    output logic                 o_pll_skip_relock,
    output logic                 o_pll_bypass,
    output logic                 o_boot_from_jtag,
    output logic [2:0]           o_pll_output_divider,
    output logic [12:0]          o_pll_feedback_mult,
    output logic [6:0]           o_pll_input_divider,
    output logic [15:0]          o_switch_clk_div,
    output logic [15:0]          o_ref_clk_div
);
    import nsc_pkg::*;

    // =========================================================
    // State
    typedef enum logic [1:0] {
        NSC_ST_CAPTURE = 2'b00,
        NSC_ST_RUN     = 2'b01
    } nsc_phase_e;

    typedef struct packed {
        nsc_phase_e     phase;
        logic [7:0]     boot_pins;
        logic [31:0]    prot;
        logic [15:0]    node_id;
        logic [31:0]    pll;
        logic [15:0]    sw_div;
        logic [15:0]    ref_div;
        logic [31:0]    dir_lo;
        logic [31:0]    dir_hi;
        logic [1:0]     rsv_a;
        logic [1:0]     rsv_b;
        nsc_rsp_s       rsp;
        nsc_route_rsp_s route;
        logic           tile_reset;
        logic           chip_reset;
    } nsc_state_s;

    nsc_state_s state_ff;
    nsc_state_s nxt_state;

    // =========================================================
    // Helpers
    function automatic logic [31:0] nsc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [31:0] mask);
        nsc_merge = (old_v & ~mask) | (new_v & mask);
    endfunction : nsc_merge

    function automatic logic [31:0] nsc_read(input nsc_state_s s, input logic [7:0] num);
        case (num)
            NSC_REG_IDENT:  nsc_read = {8'h00, s.boot_pins, SWITCH_REVISION,
                                        SWITCH_VERSION};                  // see R2
            NSC_REG_TOPO:   nsc_read = {8'h00, LINK_COUNT, SWITCH_PROCS,
                                        DEVICE_PROCS};                    // see R3
            NSC_REG_PROT:   nsc_read = s.prot;
            NSC_REG_NODEID: nsc_read = {16'h0000, s.node_id};             // see R7
            NSC_REG_PLL:    nsc_read = s.pll;
            NSC_REG_SWDIV:  nsc_read = {16'h0000, s.sw_div};
            NSC_REG_REFDIV: nsc_read = {16'h0000, s.ref_div};
            NSC_REG_SCANID: nsc_read = SCAN_ID_CODE;                      // see R16
            NSC_REG_USER:   nsc_read = {i_otp_user_code, METAL_ID_CODE};  // see R17
            NSC_REG_DIRLO:  nsc_read = s.dir_lo;
            NSC_REG_DIRHI:  nsc_read = s.dir_hi;
            NSC_REG_RSVA:   nsc_read = {30'h0000_0000, s.rsv_a};
            NSC_REG_RSVB:   nsc_read = {30'h0000_0000, s.rsv_b};
            default:        nsc_read = 32'h0000_0000;
        endcase
    endfunction : nsc_read

    // Direction nibble for the highest mismatching identity bit
    function automatic nsc_route_rsp_s nsc_lookup(input logic [15:0] dest,
                                                  input logic [15:0] own,
                                                  input logic [63:0] dirs);
        logic [15:0] diff;
        diff = dest ^ own;
        nsc_lookup.valid     = 1'b1;
        nsc_lookup.local_hit = (diff == 16'h0000);
        nsc_lookup.direction = 4'h0;
        for (int i = 0; i < 16; i++)
        begin
            if (diff[i])
            begin
                nsc_lookup.direction = dirs[4*i +: 4];                    // see R20
            end
        end
    endfunction : nsc_lookup

    // =========================================================
    // Next state
    always_comb
    begin
        logic        wr;
        logic        ctl_lock;
        logic [31:0] wd;
        wr        = 1'b0;
        ctl_lock  = 1'b0;
        wd        = 32'h0000_0000;
        nxt_state = state_ff;
        nxt_state.rsp        = '0;
        nxt_state.route      = '0;
        nxt_state.tile_reset = 1'b0;
        nxt_state.chip_reset = 1'b0;

        // Pins sampled once, on the first edge after reset release
        case (state_ff.phase)
            NSC_ST_CAPTURE:
            begin
                nxt_state.boot_pins = i_boot_control_pins;                // see R2
                nxt_state.phase     = NSC_ST_RUN;
            end
            NSC_ST_RUN:
            begin
                nxt_state.phase = NSC_ST_RUN;
            end
            default:
            begin
                nxt_state.phase = NSC_ST_RUN;
            end
        endcase

        // One answer per request; blocked writes still ack
        if (i_req.valid)                                                  // see R1
        begin
            nxt_state.rsp.valid = 1'b1;
            nxt_state.rsp.ack   = 1'b1;                                   // see R21
            nxt_state.rsp.rdata = i_req.write ? 32'h0000_0000
                                              : nsc_read(state_ff, i_req.regnum);
        end

        wr       = i_req.valid && i_req.write;
        wd       = i_req.wdata;
        ctl_lock = state_ff.prot[NSC_PROT_CTL_BIT];                       // see R4

        if (wr)
        begin
            case (i_req.regnum)
                // The lock bit itself stays writable so it can be released
                NSC_REG_PROT:
                begin
                    nxt_state.prot = nsc_merge(32'h0000_0000, wd, NSC_PROT_MASK);
                end
                NSC_REG_NODEID:
                begin
                    if (!ctl_lock)                                        // see R4
                    begin
                        nxt_state.node_id = wd[15:0];                     // see R7
                    end
                end
                NSC_REG_PLL:
                begin
                    if (!state_ff.prot[NSC_PROT_PLL_BIT])                 // see R5
                    begin
                        nxt_state.pll        = nsc_merge(32'h0000_0000, wd,
                                                         NSC_PLL_MASK);   // see R13
                        nxt_state.tile_reset = 1'b1;                      // see R8
                        nxt_state.chip_reset = !wd[NSC_PLL_NORST_BIT];    // see R9
                    end
                end
                NSC_REG_SWDIV:
                begin
                    if (!ctl_lock)
                    begin
                        nxt_state.sw_div = wd[15:0];                      // see R14
                    end
                end
                NSC_REG_REFDIV:
                begin
                    if (!ctl_lock)
                    begin
                        nxt_state.ref_div = wd[15:0];                     // see R15
                    end
                end
                NSC_REG_DIRLO:
                begin
                    if (!ctl_lock)
                    begin
                        nxt_state.dir_lo = wd;                            // see R18
                    end
                end
                NSC_REG_DIRHI:
                begin
                    if (!ctl_lock)
                    begin
                        nxt_state.dir_hi = wd;                            // see R19
                    end
                end
                NSC_REG_RSVA:
                begin
                    if (!ctl_lock)
                    begin
                        nxt_state.rsv_a = wd[1:0];
                    end
                end
                NSC_REG_RSVB:
                begin
                    if (!ctl_lock)
                    begin
                        nxt_state.rsv_b = wd[1:0];
                    end
                end
                // Read-only and unmapped numbers ignore writes
                default:
                begin
                    nxt_state.rsv_b = state_ff.rsv_b;
                end
            endcase
        end

        if (i_route.valid)
        begin
            nxt_state.route = nsc_lookup(i_route.dest, state_ff.node_id,
                                         {state_ff.dir_hi, state_ff.dir_lo});
        end
    end

    // =========================================================
    // Registers
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_ff.phase      <= NSC_ST_CAPTURE;
            state_ff.boot_pins  <= 8'h00;
            state_ff.prot       <= NSC_PROT_RST;
            state_ff.node_id    <= NSC_NODEID_RST;
            state_ff.pll        <= NSC_PLL_RST;
            state_ff.sw_div     <= NSC_SWDIV_RST;
            state_ff.ref_div    <= NSC_REFDIV_RST;
            state_ff.dir_lo     <= NSC_DIR_RST;
            state_ff.dir_hi     <= NSC_DIR_RST;
            state_ff.rsv_a      <= NSC_RSV_RST;
            state_ff.rsv_b      <= NSC_RSV_RST;
            state_ff.rsp        <= '0;
            state_ff.route      <= '0;
            state_ff.tile_reset <= 1'b0;
            state_ff.chip_reset <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // =========================================================
    // Outputs, all straight from flops
    assign o_rsp                = state_ff.rsp;
    assign o_route              = state_ff.route;
    assign o_one_byte_header    = state_ff.prot[NSC_PROT_HDR_BIT];        // see R6
    assign o_node_id            = state_ff.node_id;
    assign o_tile_reset         = state_ff.tile_reset;
    assign o_chip_reset         = state_ff.chip_reset;
    assign o_pll_skip_relock    = state_ff.pll[NSC_PLL_NOWAIT_BIT];       // see R10
    assign o_pll_bypass         = state_ff.pll[NSC_PLL_BYP_BIT];          // see R11
    assign o_boot_from_jtag     = state_ff.pll[NSC_PLL_JTAG_BIT];         // see R12
    assign o_pll_output_divider = state_ff.pll[NSC_PLL_OD_MSB:NSC_PLL_OD_LSB];
    assign o_pll_feedback_mult  = state_ff.pll[NSC_PLL_F_MSB:NSC_PLL_F_LSB];
    assign o_pll_input_divider  = state_ff.pll[NSC_PLL_R_MSB:NSC_PLL_R_LSB];
    assign o_switch_clk_div     = state_ff.sw_div;
    assign o_ref_clk_div        = state_ff.ref_div;

endmodule : nsc_config_bank

`default_nettype wire

// *** testbench/nsc_requester.sv ***
/*
 * Requester model: issues node configuration reads and writes by number.
 * Assumes the bench calls issue and idle from one process only.
 */
`timescale 1ns/1ps
`default_nettype none

module nsc_requester
    import nsc_pkg::*;
(
    // Clock
    input  wire logic            i_mclk,
    // Requests towards the bank
    output var nsc_pkg::nsc_req_s o_req
);
    initial o_req = '0;

    // =========================================================
    // Request issue
    // Bit 30 of a PLL value is only set by callers making gradual changes
    task automatic issue(input logic w, input logic [7:0] r, input logic [31:0] d);
        @(posedge i_mclk);
        o_req.valid  <= 1'b1;
        o_req.write  <= w;
        o_req.regnum <= r;
        // Reads carry no data, so show a changing pattern rather than the last word
        o_req.wdata  <= w ? d : ~o_req.wdata;
    endtask : issue

    task automatic idle();
        @(posedge i_mclk);
        o_req.valid <= 1'b0;
        o_req.wdata <= ~o_req.wdata;
    endtask : idle
endmodule : nsc_requester
`default_nettype wire

// *** testbench/nsc_config_bank_properties.sv ***
/*
 * Port checker of the configuration bank, bound to its top module.
 * Assumes the lock bits are only changed by writes to register 0x04.
 */
`timescale 1ns/1ps
`default_nettype none

module nsc_bank_props
    import nsc_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_mclk,
    input  wire logic                  i_reset_n,
    // Watched ports
    input  wire nsc_pkg::nsc_req_s      i_req,
    input  wire nsc_pkg::nsc_rsp_s      o_rsp,
    input  wire nsc_pkg::nsc_route_req_s i_route,
    input  wire nsc_pkg::nsc_route_rsp_s o_route,
    input  wire logic                  o_one_byte_header,
    input  wire logic [15:0]           o_node_id,
    input  wire logic                  o_tile_reset,
    input  wire logic                  o_chip_reset,
    input  wire logic                  o_pll_skip_relock,
    input  wire logic                  o_pll_bypass,
    input  wire logic                  o_boot_from_jtag,
    input  wire logic [2:0]            o_pll_output_divider,
    input  wire logic [12:0]           o_pll_feedback_mult,
    input  wire logic [6:0]            o_pll_input_divider
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    // =========================================================
    // Shadow of the lock bits, since they are not visible at the ports
    logic lk_ctl_ff;
    logic lk_pll_ff;
    wire  wr_en  = i_req.valid && i_req.write;
    wire  hdr_wr = wr_en && i_req.regnum == NSC_REG_PROT;
    wire  id_wr  = wr_en && i_req.regnum == NSC_REG_NODEID;
    wire  pll_wr = wr_en && i_req.regnum == NSC_REG_PLL;
    wire  pll_ok = pll_wr && !lk_pll_ff;

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            lk_ctl_ff <= 1'b0;
            lk_pll_ff <= 1'b0;
        end
        else if (hdr_wr)
        begin
            lk_ctl_ff <= i_req.wdata[31];
            lk_pll_ff <= i_req.wdata[8];
        end
    end

    // =========================================================
    // Assertions
    a_rsp_next: assert property (i_req.valid |=> o_rsp.valid && o_rsp.ack)
        else $error("answer missing after request");
    a_rsp_quiet: assert property (!i_req.valid |=> !o_rsp.valid)
        else $error("answer without request");
    a_pll_pulse: assert property (pll_ok |=> o_tile_reset)
        else $error("tile reset missing after PLL write");
    a_pll_chip: assert property (pll_ok |=> o_chip_reset == !$past(i_req.wdata[31]))
        else $error("chip reset wrong after PLL write");
    a_no_stray: assert property (!pll_ok |=> !o_tile_reset && !o_chip_reset)
        else $error("reset pulse without accepted PLL write");
    a_pll_fields: assert property (pll_ok |=> o_pll_output_divider == $past(i_req.wdata[25:23])
        && o_pll_feedback_mult == $past(i_req.wdata[20:8])
        && o_pll_input_divider == $past(i_req.wdata[6:0]))
        else $error("PLL divider fields wrong");
    a_pll_flags: assert property (pll_ok |=> {o_pll_skip_relock, o_pll_bypass, o_boot_from_jtag}
        == $past(i_req.wdata[30:28]))
        else $error("PLL flag bits wrong");
    a_pll_locked: assert property (pll_wr && lk_pll_ff |=> $stable(o_pll_feedback_mult)
        && $stable(o_pll_bypass))
        else $error("locked PLL register changed");
    a_header_sel: assert property (hdr_wr |=> o_one_byte_header == $past(i_req.wdata[0]))
        else $error("header mode not taken");
    a_id_write: assert property (id_wr && !lk_ctl_ff |=> o_node_id == $past(i_req.wdata[15:0]))
        else $error("node identity not written");
    a_id_locked: assert property (id_wr && lk_ctl_ff |=> $stable(o_node_id))
        else $error("locked node identity changed");
    a_route_next: assert property (i_route.valid |=> o_route.valid)
        else $error("route answer missing");
    a_local_hit: assert property (i_route.valid && !i_req.valid && i_route.dest == o_node_id
        |=> o_route.local_hit && o_route.direction == 4'h0)
        else $error("own identity not reported local");

    c_pll_ok:  cover property (pll_ok);
    c_pll_blk: cover property (pll_wr && lk_pll_ff);
    c_id_blk:  cover property (id_wr && lk_ctl_ff);
endmodule : nsc_bank_props

bind nsc_config_bank nsc_bank_props chk_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_req(i_req), .o_rsp(o_rsp), .i_route(i_route), .o_route(o_route),
    .o_one_byte_header(o_one_byte_header), .o_node_id(o_node_id),
    .o_tile_reset(o_tile_reset), .o_chip_reset(o_chip_reset),
    .o_pll_skip_relock(o_pll_skip_relock), .o_pll_bypass(o_pll_bypass),
    .o_boot_from_jtag(o_boot_from_jtag), .o_pll_output_divider(o_pll_output_divider),
    .o_pll_feedback_mult(o_pll_feedback_mult), .o_pll_input_divider(o_pll_input_divider));
`default_nettype wire

// *** testbench/nsc_config_bank_bench.sv ***
/*
 * Self-checking bench of the configuration bank with the requester model.
 * Assumes answers come one cycle after each request, in order.
 */
`timescale 1ns/1ps
`default_nettype none

module nsc_config_bank_bench;
    import nsc_pkg::*;
    localparam logic [7:0]  REV = 8'h12;
    localparam logic [7:0]  VER = 8'h34;
    // Arbitrary identification values
    localparam logic [31:0] SID = 32'h1357_9BDF;
    localparam logic [17:0] MID = 18'h2_4680;
    localparam logic [7:0]  RA [13] = '{8'h00, 8'h01, 8'h02, 8'h09, 8'h0A, 8'h04, 8'h05,
                                        8'h07, 8'h08, 8'h0C, 8'h0D, 8'h10, 8'h11};
    localparam logic [7:0]  WA [7] = '{8'h05, 8'h07, 8'h08, 8'h0C, 8'h0D, 8'h10, 8'h11};
    localparam logic [31:0] WM [7] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, '1, '1, 32'h3, 32'h3};
    logic i_mclk, i_reset_n, hdr, trst, crst, skip, byp, jtag;
    logic [7:0]  pins;
    logic [13:0] otp;
    logic [2:0]  od;
    logic [12:0] fm;
    logic [6:0]  idv;
    logic [15:0] nid, swd, rfd;
    logic [31:0] seed, v, d, re [13], wv [7];
    logic [32:0] rsp_q [$], e1;
    logic [4:0]  rt_q [$], e2;
    nsc_req_s req;
    nsc_rsp_s rsp;
    nsc_route_req_s rt;
    nsc_route_rsp_s rr;
    int mismatches, num_checks, n_trst, n_crst;

    nsc_requester req_u (.i_mclk(i_mclk), .o_req(req));
    nsc_config_bank #(.SWITCH_REVISION(REV), .SWITCH_VERSION(VER), .LINK_COUNT(8'h08),
        .SWITCH_PROCS(8'h02), .DEVICE_PROCS(8'h04), .SCAN_ID_CODE(SID), .METAL_ID_CODE(MID))
    dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_boot_control_pins(pins),
        .i_otp_user_code(otp), .i_req(req), .o_rsp(rsp), .i_route(rt), .o_route(rr),
        .o_one_byte_header(hdr), .o_node_id(nid), .o_tile_reset(trst), .o_chip_reset(crst),
        .o_pll_skip_relock(skip), .o_pll_bypass(byp), .o_boot_from_jtag(jtag),
        .o_pll_output_divider(od), .o_pll_feedback_mult(fm), .o_pll_input_divider(idv),
        .o_switch_clk_div(swd), .o_ref_clk_div(rfd));

    // =========================================================
    // Shared tasks
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] r, input logic [31:0] e);
        req_u.issue(1'b0, r, 32'h0);
        rsp_q.push_back({1'b1, e});
    endtask : rd

    task automatic wr(input logic [7:0] r, input logic [31:0] w);
        req_u.issue(1'b1, r, w);
        rsp_q.push_back({1'b1, 32'h0});
    endtask : wr

    task automatic route(input logic [15:0] dst, input logic [4:0] e);
        @(posedge i_mclk);
        rt <= '{valid: 1'b1, dest: dst};
        rt_q.push_back(e);
    endtask : route

    task automatic wrap_up();
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // =========================================================
    // Clock, watchdog and answer monitor
    initial
    begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    initial
    begin
        #50000;
        mismatches++;
        wrap_up();
    end

    always @(negedge i_mclk)
    begin
        if (rsp.valid === 1'b1)
        begin
            e1 = rsp_q.size() > 0 ? rsp_q.pop_front() : 'x;
            chk({rsp.ack, rsp.rdata}, e1);
        end
        if (rr.valid === 1'b1)
        begin
            e2 = rt_q.size() > 0 ? rt_q.pop_front() : 'x;
            chk({28'h0, rr.local_hit, rr.direction}, {28'h0, e2});
        end
        if (trst === 1'b1) n_trst++;
        if (crst === 1'b1) n_crst++;
    end

    // =========================================================
    // Main sequence
    initial
    begin
        i_reset_n = 1'b0;
        pins = 8'hA5;
        otp = 14'h2AB;
        rt = '0;
        seed = 32'hedfd;
        re = '{{8'h00, 8'hA5, REV, VER}, 32'h0008_0204, 32'h0, SID, {14'h2AB, MID},
               32'h0, 32'h0, 32'h0, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0};
        repeat (8) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        repeat (2) @(posedge i_mclk);
        // Pins move after capture; identification must keep the captured levels
        pins <= 8'h3C;
        foreach (RA[k]) rd(RA[k], re[k]);
        for (int k = 0; k < 5; k++) wr(RA[k], $random(seed));
        for (int k = 0; k < 5; k++) rd(RA[k], re[k]);
        foreach (WA[k])
        begin
            wv[k] = $random(seed);
            wr(WA[k], wv[k]);
            rd(WA[k], wv[k] & WM[k]);
        end
        wr(NSC_REG_PROT, '1);
        rd(NSC_REG_PROT, 32'h8000_0101);
        @(negedge i_mclk) chk({32'h0, hdr}, 33'h1);
        foreach (WA[k]) wr(WA[k], ~wv[k]);
        wr(NSC_REG_PLL, $random(seed));
        foreach (WA[k]) rd(WA[k], wv[k] & WM[k]);
        rd(NSC_REG_PLL, 32'h0);
        chk({1'b0, swd, rfd}, {1'b0, wv[1][15:0], wv[2][15:0]});
        wr(NSC_REG_PROT, 32'h0);
        rd(NSC_REG_PROT, 32'h0);
        @(negedge i_mclk) chk({32'h0, hdr}, 33'h0);
        v = $random(seed) & 32'h7FFF_FFFF;
        wr(NSC_REG_PLL, v);
        rd(NSC_REG_PLL, v & NSC_PLL_MASK);
        @(negedge i_mclk) chk({7'h0, skip, byp, jtag, od, fm, idv},
            {7'h0, v[30:28], v[25:23], v[20:8], v[6:0]});
        v = $random(seed) | 32'h8000_0000;
        wr(NSC_REG_PLL, v);
        rd(NSC_REG_PLL, v & NSC_PLL_MASK);
        wr(NSC_REG_NODEID, 32'h1234);
        wr(NSC_REG_DIRLO, 32'h7654_3210);
        wr(NSC_REG_DIRHI, 32'hFEDC_BA98);
        req_u.idle();
        chk(33'(n_trst), 33'd2);
        chk(33'(n_crst), 33'd1);
        for (int b = 0; b < 16; b++)
        begin
            d = (32'h1 << b) | ($random(seed) & ((32'h1 << b) - 1));
            route(16'h1234 ^ d[15:0], {1'b0, 4'(b)});
        end
        route(16'h1234, 5'h10);
        @(posedge i_mclk);
        rt.valid <= 1'b0;
        repeat (4) @(posedge i_mclk);
        chk({32'h0, rsp_q.size() == 0 && rt_q.size() == 0}, 33'h1);
        wrap_up();
    end
endmodule : nsc_config_bank_bench
`default_nettype wire
